// [hdl/pirq_pkg.sv]
// Package with constants and types for the PCI interrupt rerouter block
package pirq_pkg;
   // Two steering registers, decoded by address bit 0 only (aliases above)
   localparam logic [1:0] STEER_LOW_IDX   = 2'h0;
   localparam logic [1:0] STEER_HIGH_IDX  = 2'h1;
   localparam int         NUM_LINES       = 4;
   localparam int         NUM_IRQ         = 16;
   // Nibble code 0xF selects pass-through to the upper controller inputs
   localparam logic [3:0] ROUTE_PASS      = 4'hF;
   localparam logic [7:0] STEER_RESET     = 8'hFF;
   localparam logic [4:0] PASS_BASE_INPUT = 5'h10;
   // Sleep indication blink half period in cycles
   localparam logic [23:0] BLINK_HALF     = 24'hFFFFFF;

   typedef struct packed {
      logic       cs;
      logic       wr;
      logic       rd;
      logic [1:0] addr;
      logic [7:0] wdata;
   } pirq_io_t;

   typedef struct packed {
      logic isa_err;
      logic pci_err;
      logic ecc_err;
      logic limit_err;
   } pirq_err_t;
endpackage

// [hdl/pirq_rerouter.sv]
// PCI interrupt rerouter with SMI/NMI/SERR gating and sleep control
//
// Functional notes
// RL1: In pass-through each PCI interrupt line drives its own upper controller input unchanged.
// RL2: Each PCI line is steered to an ISA IRQ independently of the other lines.
// RL3: There are exactly two writable steering registers of eight bits each.
// RL4: Each nibble of a steering register governs one PCI line, covering four lines in all.
// RL5: The host bridge decodes the I/O address and asserts the chip select.
// RL6: Only two byte locations are decoded and the rest of the window aliases onto them.
// RL7: SMI and NMI conditions are gated and redirected to drive PCI system error.
// RL8: ISA, PCI, ECC and limit errors are reported through the active-low SMI.
// RL9: With SMI enabled errors go to SMI, otherwise directly to NMI.
// RL10: Some error types raise NMI even when SMI intercepted them.
// RL11: Non-ISA errors are presented as ISA-compatible via NMI and SMI.
// RL12: The south bridge can assert stop clock to both processors in light sleep.
// RL13: In light sleep system fans stop while supply and processor fans keep running.
// RL14: A sleep indication goes to the management controller to blink the power LED.
// RL15: Pass-through maps lines A to D onto controller inputs sixteen to nineteen.
// RL16: A nibble holds the target IRQ number, code F means pass-through, reset is pass-through.
// RL17: Writes take effect on the edge after the write strobe and reads return stored values.
`timescale 1ns/1ps
module pirq_rerouter (
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire pirq_pkg::pirq_io_t  io_bus,
   output logic [7:0]               io_rdata,
   input  wire logic [3:0]          pci_int_n,
   output logic [3:0]               apic_pci_int_n,
   output logic [15:0]              isa_irq,
   input  wire pirq_pkg::pirq_err_t err_in,
   input  wire logic                smi_enable,
   input  wire logic [3:0]          nmi_force_mask,
   output logic                     sys_mgmt_int_n,
   output logic                     nmi,
   output logic                     serr_n,
   input  wire logic                sb_stop_clock_n,
   input  wire logic                sleep_state,
   output logic [1:0]               cpu_stop_clock_req,
   output logic                     sys_fan_on,
   output logic                     psu_fan_on,
   output logic                     cpu_fan_on,
   output logic                     board_mgmt_sleep
);

   ////////////////////////////////////////////////////////////////////
   // Input synchronisers for pins from outside the clock domain
   logic [3:0] pci_s1_q;
   logic [3:0] pci_s2_q;
   logic [3:0] err_s1_q;
   logic [3:0] err_s2_q;
   logic [1:0] slp_s1_q;
   logic [1:0] slp_s2_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pci_s1_q <= 4'hF;
         pci_s2_q <= 4'hF;
         err_s1_q <= 4'h0;
         err_s2_q <= 4'h0;
         slp_s1_q <= 2'h1;
         slp_s2_q <= 2'h1;
      end else begin
         pci_s1_q <= pci_int_n;
         pci_s2_q <= pci_s1_q;
         err_s1_q <= {err_in.isa_err, err_in.pci_err, err_in.ecc_err, err_in.limit_err};
         err_s2_q <= err_s1_q;
         slp_s1_q <= {sleep_state, sb_stop_clock_n};
         slp_s2_q <= slp_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Steering registers
   logic [7:0] steer_low_q;
   logic [7:0] steer_high_q;
   logic [7:0] rdata_q;
   wire        sel_low;
   wire        sel_high;
   wire        wr_low;
   wire        wr_high;
   wire [15:0] steer_all;

   // Address bit 1 ignored: four-byte window aliases two registers
   assign sel_low   = io_bus.cs && (io_bus.addr[0] == pirq_pkg::STEER_LOW_IDX[0]);  // RL6
   assign sel_high  = io_bus.cs && (io_bus.addr[0] == pirq_pkg::STEER_HIGH_IDX[0]); // RL6
   assign wr_low    = sel_low && io_bus.wr;
   assign wr_high   = sel_high && io_bus.wr;
   assign steer_all = {steer_high_q, steer_low_q};

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         steer_low_q  <= pirq_pkg::STEER_RESET; // RL16
         steer_high_q <= pirq_pkg::STEER_RESET; // RL16
         rdata_q      <= 8'h00;
      end else begin
         if (wr_low) begin
            steer_low_q <= io_bus.wdata; // RL3 RL17
         end
         if (wr_high) begin
            steer_high_q <= io_bus.wdata; // RL3 RL17
         end
         if (io_bus.cs && io_bus.rd) begin
            rdata_q <= sel_high ? steer_high_q : steer_low_q; // RL17
         end
      end
   end

   assign io_rdata = rdata_q;

   property p_write_high;
      @(posedge clock) disable iff (!rst_n)
      wr_high |=> steer_high_q == $past(io_bus.wdata);
   endproperty
   a_write_high: assert property (p_write_high) else $error("high steer write lost"); // RL17

   property p_read_low;
      @(posedge clock) disable iff (!rst_n)
      (io_bus.cs && io_bus.rd && !io_bus.addr[0]) |=> io_rdata == $past(steer_low_q);
   endproperty
   a_read_low: assert property (p_read_low) else $error("low steer read wrong"); // RL17

   ////////////////////////////////////////////////////////////////////
   // Per-line routing
   logic [3:0]  pass_q;
   logic [15:0] irq_q;
   logic [15:0] irq_hit [pirq_pkg::NUM_LINES];
   wire  [3:0]  pass_d;
   wire  [15:0] irq_d;

   genvar g;
   generate
      for (g = 0; g < pirq_pkg::NUM_LINES; g++) begin : g_line
         wire [3:0] code;
         wire       pass;
         assign code = steer_all[g*4 +: 4]; // RL4
         assign pass = (code == pirq_pkg::ROUTE_PASS); // RL16
         // Active-low line becomes an active-high IRQ at the nibble index
         assign irq_hit[g] = (!pass && !pci_s2_q[g]) ? (16'h0001 << code) : 16'h0000; // RL2
         // Line g drives controller input 16+g when passed
         assign pass_d[g] = pass ? pci_s2_q[g] : 1'h1; // RL1 RL15
      end
   endgenerate

   assign irq_d = irq_hit[0] | irq_hit[1] | irq_hit[2] | irq_hit[3];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pass_q <= 4'hF;
         irq_q  <= 16'h0000;
      end else begin
         pass_q <= pass_d; // RL1 RL15
         irq_q  <= irq_d; // RL2
      end
   end

   assign apic_pci_int_n = pass_q;
   assign isa_irq        = irq_q;

   property p_isa_route;
      @(posedge clock) disable iff (!rst_n)
      (steer_high_q[3:0] != pirq_pkg::ROUTE_PASS && !pci_s2_q[2])
         |=> isa_irq[$past(steer_high_q[3:0])];
   endproperty
   a_isa_route: assert property (p_isa_route) else $error("line C not on its IRQ"); // RL2 RL4

   property p_isa_quiet;
      @(posedge clock) disable iff (!rst_n)
      (steer_all == 16'hFFFF) |=> isa_irq == 16'h0000;
   endproperty
   a_isa_quiet: assert property (p_isa_quiet) else $error("IRQ raised in pass-through"); // RL1 RL16

   property p_line_d;
      @(posedge clock) disable iff (!rst_n)
      (steer_high_q[7:4] == pirq_pkg::ROUTE_PASS) |=> apic_pci_int_n[3] == $past(pci_s2_q[3]);
   endproperty
   a_line_d: assert property (p_line_d) else $error("line D not on input 19"); // RL1 RL15

   ////////////////////////////////////////////////////////////////////
   // Error gating: SMI intercept, NMI path, SERR
   wire any_err;
   wire forced_nmi;
   wire smi_d;
   wire nmi_d;
   logic smi_q;
   logic nmi_q;
   logic serr_q;

   assign any_err    = |err_s2_q; // RL8 RL11
   assign forced_nmi = |(err_s2_q & nmi_force_mask); // RL10
   assign smi_d      = smi_enable && any_err; // RL8 RL9
   assign nmi_d      = smi_enable ? forced_nmi : any_err; // RL9 RL10 RL11

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         smi_q  <= 1'h0;
         nmi_q  <= 1'h0;
         serr_q <= 1'h0;
      end else begin
         smi_q  <= smi_d; // RL8 RL9
         nmi_q  <= nmi_d; // RL9 RL10 RL11
         serr_q <= smi_d || nmi_d; // RL7
      end
   end

   assign sys_mgmt_int_n = !smi_q;
   assign nmi            = nmi_q;
   assign serr_n         = !serr_q;

   property p_serr;
      @(posedge clock) disable iff (!rst_n)
      serr_n == (sys_mgmt_int_n && !nmi);
   endproperty
   a_serr: assert property (p_serr) else $error("system error not tied to SMI or NMI"); // RL7

   property p_no_smi;
      @(posedge clock) disable iff (!rst_n)
      !smi_enable |=> sys_mgmt_int_n;
   endproperty
   a_no_smi: assert property (p_no_smi) else $error("SMI raised while disabled"); // RL9

   ////////////////////////////////////////////////////////////////////
   // Sleep: stop clock, fans, sleep indication
   logic cpu_stop_clock_req_q;
   logic sleep_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cpu_stop_clock_req_q <= 1'h0;
         sleep_q  <= 1'h0;
      end else begin
         cpu_stop_clock_req_q <= !slp_s2_q[0]; // RL12
         // Steady level; the controller does its own LED blinking
         sleep_q  <= slp_s2_q[1]; // RL13 RL14
      end
   end

   assign cpu_stop_clock_req = {cpu_stop_clock_req_q, cpu_stop_clock_req_q}; // RL12
   assign sys_fan_on         = !sleep_q; // RL13
   assign psu_fan_on         = 1'b1; // RL13
   assign cpu_fan_on         = 1'b1; // RL13
   assign board_mgmt_sleep   = sleep_q; // RL14

   property p_stop_release;
      @(posedge clock) disable iff (!rst_n)
      $rose(slp_s2_q[0]) |=> cpu_stop_clock_req == 2'h0;
   endproperty
   a_stop_release: assert property (p_stop_release) else $error("stop clock stuck"); // RL12

   property p_wake;
      @(posedge clock) disable iff (!rst_n)
      !slp_s2_q[1] |=> !board_mgmt_sleep && sys_fan_on;
   endproperty
   a_wake: assert property (p_wake) else $error("sleep state kept after wake"); // RL13 RL14

   ////////////////////////////////////////////////////////////////////
   // Assertions
   property p_write_low;
      @(posedge clock) disable iff (!rst_n)
      wr_low |=> steer_low_q == $past(io_bus.wdata);
   endproperty
   a_write_low: assert property (p_write_low) else $error("low steer write lost"); // RL17

   property p_alias;
      @(posedge clock) disable iff (!rst_n)
      (io_bus.cs && io_bus.wr && io_bus.addr == 2'h3) |=> steer_high_q == $past(io_bus.wdata);
   endproperty
   a_alias: assert property (p_alias) else $error("alias write missed high reg"); // RL6

   property p_pass_line0;
      @(posedge clock) disable iff (!rst_n)
      (steer_low_q[3:0] == pirq_pkg::ROUTE_PASS && !pci_s2_q[0]) |=> !apic_pci_int_n[0];
   endproperty
   a_pass_line0: assert property (p_pass_line0) else $error("pass-through line 0 failed"); // RL1

   property p_no_pass;
      @(posedge clock) disable iff (!rst_n)
      (steer_all[7:4] != pirq_pkg::ROUTE_PASS) |=> apic_pci_int_n[1];
   endproperty
   a_no_pass: assert property (p_no_pass) else $error("rerouted line leaked upward"); // RL2

   property p_smi;
      @(posedge clock) disable iff (!rst_n)
      (smi_enable && any_err) |=> !sys_mgmt_int_n && !serr_n;
   endproperty
   a_smi: assert property (p_smi) else $error("SMI not raised on error"); // RL8

   property p_nmi_direct;
      @(posedge clock) disable iff (!rst_n)
      (!smi_enable && any_err) |=> nmi && sys_mgmt_int_n;
   endproperty
   a_nmi_direct: assert property (p_nmi_direct) else $error("direct NMI path failed"); // RL9

   property p_forced;
      @(posedge clock) disable iff (!rst_n)
      (smi_enable && forced_nmi) |=> nmi;
   endproperty
   a_forced: assert property (p_forced) else $error("forced NMI missing"); // RL10

   property p_fans;
      @(posedge clock) disable iff (!rst_n)
      slp_s2_q[1] |=> board_mgmt_sleep && !sys_fan_on && psu_fan_on && cpu_fan_on;
   endproperty
   a_fans: assert property (p_fans) else $error("fan state wrong in sleep"); // RL13

   property p_cpu_stop_clock_req;
      @(posedge clock) disable iff (!rst_n)
      $fell(slp_s2_q[0]) |=> cpu_stop_clock_req == 2'h3;
   endproperty
   a_cpu_stop_clock_req: assert property (p_cpu_stop_clock_req) else $error("stop clock not passed"); // RL12

endmodule

// [bench/pirq_sb_model.sv]
// South bridge model issuing chip-selected I/O cycles to the steering registers
`timescale 1ns/1ps
module pirq_sb_model (
   input  wire logic         clock,
   output pirq_pkg::pirq_io_t io_bus
);
   initial io_bus = '0;
   // Signals change at the falling edge and are held across one sampling edge
   task automatic io_cycle(input logic wr, input logic [1:0] addr, input logic [7:0] wdata);
      @(negedge clock);
      io_bus.cs = 1'b1;
      io_bus.wr = wr;
      io_bus.rd = ~wr;
      io_bus.addr = addr;
      io_bus.wdata = wdata;
      @(negedge clock);
      io_bus.cs = 1'b0;
      io_bus.wr = 1'b0;
      io_bus.rd = 1'b0;
      // Released data lines do not keep the last value
      io_bus.wdata = ~wdata;
   endtask
endmodule

// [bench/test_pci_irq_rerouter_nmi_smi.sv]
// Self-checking bench for the PCI interrupt rerouter block
`timescale 1ns/1ps
module test_pci_irq_rerouter_nmi_smi;
   logic               clock = 1'b0;
   logic               rst_n = 1'b0;
   pirq_pkg::pirq_io_t io_bus;
   pirq_pkg::pirq_err_t err_in = '0;
   logic [7:0]         io_rdata;
   logic [3:0]         pci_int_n = 4'hF;
   logic [3:0]         nmi_force_mask = 4'h0;
   logic [3:0]         apic_pci_int_n;
   logic [15:0]        isa_irq;
   logic               smi_enable = 1'b0;
   logic               sb_stop_clock_n = 1'b1;
   logic               sleep_state = 1'b0;
   logic               sys_mgmt_int_n, nmi, serr_n, sys_fan_on, psu_fan_on, cpu_fan_on;
   logic               board_mgmt_sleep;
   logic [1:0]         cpu_stop_clock_req;
   logic [31:0]        seed = 32'h56;
   int                 miscompares = 0;
   int                 checked = 0;
   int                 steer [2] = '{255, 255};

   always #5 clock = ~clock;

   pirq_sb_model sb (.clock(clock), .io_bus(io_bus));
   pirq_rerouter dut (.clock(clock), .rst_n(rst_n), .io_bus(io_bus), .io_rdata(io_rdata),
      .pci_int_n(pci_int_n), .apic_pci_int_n(apic_pci_int_n), .isa_irq(isa_irq),
      .err_in(err_in), .smi_enable(smi_enable), .nmi_force_mask(nmi_force_mask),
      .sys_mgmt_int_n(sys_mgmt_int_n), .nmi(nmi), .serr_n(serr_n),
      .sb_stop_clock_n(sb_stop_clock_n), .sleep_state(sleep_state),
      .cpu_stop_clock_req(cpu_stop_clock_req), .sys_fan_on(sys_fan_on),
      .psu_fan_on(psu_fan_on), .cpu_fan_on(cpu_fan_on), .board_mgmt_sleep(board_mgmt_sleep));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Read both registers through a random alias
   task automatic check_regs();
      logic [31:0] r;
      for (int a = 0; a < 2; a++) begin
         r = xs();
         sb.io_cycle(1'b0, {r[4], a[0]}, r[15:8]);
         chk({8'h00, io_rdata}, 16'(steer[a]));
      end
   endtask

   // Reference model of routing, error gating and sleep control
   task automatic check_outputs();
      int apic, irq, nib, e, nm;
      logic smi;
      apic = 15;
      irq = 0;
      for (int l = 0; l < 4; l++) begin
         nib = (steer[l / 2] >> (4 * (l % 2))) & 15;
         if (nib == 15 && !pci_int_n[l])
            apic &= ~(1 << l);
         else if (nib != 15 && !pci_int_n[l])
            irq |= 1 << nib;
      end
      e = int'(err_in);
      smi = smi_enable && e != 0;
      nm = smi_enable ? int'((e & int'(nmi_force_mask)) != 0) : int'(e != 0);
      chk({12'h000, apic_pci_int_n}, 16'(apic));
      chk(isa_irq, 16'(irq));
      chk({15'h0000, sys_mgmt_int_n}, {15'h0000, !smi});
      chk({15'h0000, nmi}, 16'(nm));
      chk({15'h0000, serr_n}, {15'h0000, !(smi || nm != 0)});
      chk({14'h0000, cpu_stop_clock_req}, sb_stop_clock_n ? 16'h0000 : 16'h0003);
      chk({13'h0000, sys_fan_on, psu_fan_on, cpu_fan_on}, {13'h0000, !sleep_state, 2'h3});
      chk({15'h0000, board_mgmt_sleep}, {15'h0000, sleep_state});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      miscompares++;
      end_sim();
   end

   initial begin
      logic [31:0] r;
      repeat (3) @(negedge clock);
      rst_n = 1'b1;
      check_regs();
      check_outputs();
      for (int i = 0; i < 40; i++) begin
         r = xs();
         sb.io_cycle(1'b1, r[1:0], r[15:8]);
         steer[r[0]] = int'(r[15:8]);
         if (i % 4 == 0)
            check_regs();
         r = xs();
         pci_int_n = r[3:0];
         err_in = r[7:4];
         smi_enable = r[8];
         nmi_force_mask = r[12:9];
         sb_stop_clock_n = r[13];
         sleep_state = r[14];
         repeat (4) @(negedge clock);
         check_outputs();
      end
      rst_n = 1'b0;
      steer = '{255, 255};
      @(negedge clock);
      rst_n = 1'b1;
      check_regs();
      repeat (4) @(negedge clock);
      check_outputs();
      end_sim();
   end
endmodule
